// file: core/fbgd_phase.v
`timescale 1ns/1ps
`default_nettype none
`include "fbgd_defines.vh"
module fbgd_phase (
	// clock and reset
	input wire clk,
	input wire rst_n,
	// control
	input wire enable,
	input wire highCmd,
	input wire lowCmd,
	input wire bootLow,
	input wire bootOk,
	input wire [12:0] deadCyc,
	// outputs
	output reg highGate,
	output reg lowGate,
	output reg chargeTimeout
);
	reg [2:0] state_q;
	reg [2:0] target_q;
	reg [12:0] deadCnt_q;
	reg [12:0] sinceOff_q;
	reg [12:0] chgCnt_q;
	reg offHigh_q;
	wire [31:0] chgTmo32 = `FBGD_CHG_TMO_CYC;
	wire [31:0] chgMin32 = `FBGD_CHG_MIN_CYC;
	wire [12:0] chgTmoLast = chgTmo32[12:0] - 13'h1;
	wire [12:0] chgMinLast = chgMin32[12:0] - 13'h1;
	wire wantLow = lowCmd;
	wire wantHigh = highCmd & ~lowCmd;
	wire [2:0] want = wantLow ? `FBGD_ST_LOW : (wantHigh ? `FBGD_ST_HIGH : `FBGD_ST_OFF);
	// dead time only after complementary turn-off
	wire deadArmed = (deadCyc != 13'h0) && (sinceOff_q < deadCyc);
	wire needDeadLow = deadArmed & offHigh_q;
	wire needDeadHigh = deadArmed & ~offHigh_q;

	always @(posedge clk) begin
		if (!rst_n || !enable) begin
			state_q <= `FBGD_ST_OFF;
			target_q <= `FBGD_ST_OFF;
			deadCnt_q <= 13'h0;
			sinceOff_q <= 13'h1fff;
			offHigh_q <= 1'b0;
			chgCnt_q <= 13'h0;
			highGate <= 1'b0;
			lowGate <= 1'b0;
			chargeTimeout <= 1'b0;
		end else begin
			chargeTimeout <= 1'b0;
			if (sinceOff_q != 13'h1fff)
				sinceOff_q <= sinceOff_q + 13'h1;
			case (state_q)
			`FBGD_ST_OFF: begin
				if (want == `FBGD_ST_LOW) begin
					target_q <= `FBGD_ST_LOW;
					state_q <= needDeadLow ? `FBGD_ST_DEAD : `FBGD_ST_LOW;
					deadCnt_q <= 13'h0;
				end else if (want == `FBGD_ST_HIGH) begin
					if (!bootOk) begin
						target_q <= `FBGD_ST_CHG;
						chgCnt_q <= 13'h0;
						state_q <= needDeadLow ? `FBGD_ST_DEAD : `FBGD_ST_CHG;
					end else begin
						target_q <= `FBGD_ST_HIGH;
						state_q <= needDeadHigh ? `FBGD_ST_DEAD : `FBGD_ST_HIGH;
					end
					deadCnt_q <= 13'h0;
				end
			end
			`FBGD_ST_DEAD: begin
				deadCnt_q <= deadCnt_q + 13'h1;
				if (want == `FBGD_ST_OFF)
					state_q <= `FBGD_ST_OFF;
				else if (deadCnt_q + 13'h1 >= deadCyc) begin
					state_q <= target_q;
					chgCnt_q <= 13'h0;
				end
			end
			`FBGD_ST_LOW: begin
				// low command drives low side only
				lowGate <= 1'b1;
				highGate <= 1'b0;
				if (want != `FBGD_ST_LOW) begin
					lowGate <= 1'b0;
					sinceOff_q <= 13'h0;
					offHigh_q <= 1'b0;
					state_q <= `FBGD_ST_OFF;
				end
			end
			`FBGD_ST_HIGH: begin
				highGate <= 1'b1;
				lowGate <= 1'b0;
				if (want != `FBGD_ST_HIGH) begin
					highGate <= 1'b0;
					sinceOff_q <= 13'h0;
					offHigh_q <= 1'b1;
					state_q <= `FBGD_ST_OFF;
				end else if (bootLow) begin
					highGate <= 1'b0;
					sinceOff_q <= 13'h0;
					offHigh_q <= 1'b1;
					target_q <= `FBGD_ST_CHG;
					deadCnt_q <= 13'h0;
					chgCnt_q <= 13'h0;
					state_q <= (deadCyc != 13'h0) ? `FBGD_ST_DEAD : `FBGD_ST_CHG;
				end
			end
			`FBGD_ST_CHG: begin
				// charge until ok and minimum time
				lowGate <= 1'b1;
				highGate <= 1'b0;
				if (chgCnt_q != 13'h1fff)
					chgCnt_q <= chgCnt_q + 13'h1;
				if (want != `FBGD_ST_HIGH) begin
					lowGate <= 1'b0;
					sinceOff_q <= 13'h0;
					offHigh_q <= 1'b0;
					state_q <= `FBGD_ST_OFF;
				end else if (chgCnt_q >= chgTmoLast) begin
					chargeTimeout <= 1'b1;
					lowGate <= 1'b0;
					sinceOff_q <= 13'h0;
					offHigh_q <= 1'b0;
					state_q <= `FBGD_ST_OFF;
				end else if (bootOk && chgCnt_q >= chgMinLast) begin
					lowGate <= 1'b0;
					sinceOff_q <= 13'h0;
					offHigh_q <= 1'b0;
					target_q <= `FBGD_ST_HIGH;
					deadCnt_q <= 13'h0;
					state_q <= (deadCyc != 13'h0) ? `FBGD_ST_DEAD : `FBGD_ST_HIGH;
				end
			end
			default: state_q <= `FBGD_ST_OFF;
			endcase
		end
	end
endmodule
`default_nettype wire

// file: core/fbgd_sync.v
`timescale 1ns/1ps
`default_nettype none
module fbgd_sync #(
	parameter W = 1
) (
	// clock and reset
	input wire clk,
	input wire rst_n,
	// data
	input wire [W-1:0] asyncIn,
	input wire [W-1:0] resetVal,
	output reg [W-1:0] syncOut
);
	reg [W-1:0] meta_q;

	always @(posedge clk) begin
		if (!rst_n) begin
			meta_q <= resetVal;
			syncOut <= resetVal;
		end else begin
			meta_q <= asyncIn;
			syncOut <= meta_q;
		end
	end
endmodule
`default_nettype wire

// file: core/fbgd_top.v
`timescale 1ns/1ps
`default_nettype none
`include "fbgd_defines.vh"
// Contract
// - each command drives only its own side's gate, except a high command during bootstrap charge, which drives the low gate
// - both commands high: low side on, high side off
// - both commands low: both gates off
// - sleep input low forces every gate off and enters sleep
// - sleep entry clears all latched faults and the flag
// - after wake, gates stay off until charge pump ready
// - short reset pulse clears the latched bootstrap fault
// - fault line open drain: released if no fault or while asleep, driven low otherwise
// - overtemperature pulls fault low, disables nothing, unlatched
// - regulator undervoltage pulls fault low, disables outputs, unlatched
// - bootstrap low before high-side turn-on: charge via low side first
// - bootstrap low while high side on: start charge cycle
// - charge timeout latches fault, disables outputs until reset input low
// - logic undervoltage resets other faults and disables outputs
// - logic undervoltage active from power-up, unlatched
// - any disabling fault forces all gates low
// - dead time between complementary off and on, shared setting
// - dead time only if on follows complementary off closely
// - dead time: resistor value, maximum, or none
// - charge lasts until bootstrap ok, minimum charge time
// - charge not done in timeout flags bootstrap fault
module fbgd_top #(
	parameter WAKE_CYC = `FBGD_WAKE_CYC,
	parameter SLEEP_CYC = `FBGD_SLEEP_CYC,
	parameter [12:0] RES_DEAD_CYC = 13'h0014
) (
	// clock and reset
	input wire clk,
	input wire rst_n,
	// gate commands
	input wire phase_a_high_cmd,
	input wire phase_a_low_cmd,
	input wire phase_b_high_cmd,
	input wire phase_b_low_cmd,
	input wire reset_sleep_n,
	// configuration
	input wire [1:0] dead_time_select,
	// monitor comparators
	input wire overTemp,
	input wire regUnderVolt,
	input wire logicUnderVolt,
	input wire pumpReady,
	input wire [1:0] bootBelowOn,
	input wire [1:0] bootBelowOff,
	// gate outputs, index 0 phase a
	output wire [1:0] high_gate_out,
	output wire [1:0] low_gate_out,
	output wire gatesActive,
	// fault line
	output wire faultOut,
	output reg faultOe,
	output reg asleep
);
	wire [10:0] sIn;
	wire [10:0] sOut;
	assign sIn = {bootBelowOn, pumpReady, logicUnderVolt, regUnderVolt, overTemp,
		reset_sleep_n, phase_b_low_cmd, phase_b_high_cmd, phase_a_low_cmd, phase_a_high_cmd};
	fbgd_sync #(.W(11)) uSync (
		.clk(clk),
		.rst_n(rst_n),
		.asyncIn(sIn),
		.resetVal(11'h000),
		.syncOut(sOut)
	);
	wire [1:0] hiCmd = {sOut[2], sOut[0]};
	wire [1:0] loCmd = {sOut[3], sOut[1]};
	// sync resets to zero, so the sleep input reads as low
	wire rstIn = ~sOut[4];
	wire otSync = sOut[5];
	wire regUv = sOut[6];
	wire logicUv = sOut[7];
	wire pumpOk = sOut[8];
	wire [1:0] bootOnLow = sOut[10:9];
	reg [1:0] bootOffLow_q;
	wire [31:0] resPulse32 = `FBGD_RES_PULSE_CYC;
	wire [31:0] sleepCyc32 = SLEEP_CYC;
	wire [31:0] wakeCyc32 = WAKE_CYC;
	wire [31:0] deadMax32 = `FBGD_DEAD_MAX_CYC;
	reg [1:0] bootOffMeta_q;

	reg [21:0] lowCnt_q;
	reg [21:0] wakeCnt_q;
	reg awake_q;
	reg bootFault_q;
	reg [1:0] chgHigh_q;

	always @(posedge clk) begin
		if (!rst_n) begin
			bootOffMeta_q <= 2'h0;
			bootOffLow_q <= 2'h0;
		end else begin
			bootOffMeta_q <= bootBelowOff;
			bootOffLow_q <= bootOffMeta_q;
		end
	end

	// sleep entry and wake hold-off
	always @(posedge clk) begin
		if (!rst_n) begin
			lowCnt_q <= 22'h0;
			wakeCnt_q <= 22'h0;
			awake_q <= 1'b0;
			asleep <= 1'b1;
			bootFault_q <= 1'b0;
		end else begin
			if (rstIn) begin
				if (lowCnt_q != 22'h3fffff)
					lowCnt_q <= lowCnt_q + 22'h1;
				if (lowCnt_q + 22'h1 >= resPulse32[21:0])
					bootFault_q <= 1'b0;
				// held low long enough enters sleep
				if (lowCnt_q + 22'h1 >= sleepCyc32[21:0]) begin
					asleep <= 1'b1;
					bootFault_q <= 1'b0;
				end
				awake_q <= 1'b0;
				wakeCnt_q <= 22'h0;
			end else begin
				lowCnt_q <= 22'h0;
				if (asleep) begin
					// hold off until pump ready and time elapsed
					if (wakeCnt_q != 22'h3fffff)
						wakeCnt_q <= wakeCnt_q + 22'h1;
					if (pumpOk && wakeCnt_q + 22'h1 >= wakeCyc32[21:0]) begin
						asleep <= 1'b0;
						awake_q <= 1'b1;
					end
				end else
					awake_q <= 1'b1;
			end
			if (logicUv)
				bootFault_q <= 1'b0;
			else if (|chgHigh_q)
				bootFault_q <= 1'b1;
		end
	end

	reg [12:0] deadCyc;
	always @* begin
		case (dead_time_select)
		`FBGD_DT_NONE: deadCyc = 13'h0;
		`FBGD_DT_RES: deadCyc = RES_DEAD_CYC;
		`FBGD_DT_MAX: deadCyc = deadMax32[12:0];
		default: deadCyc = deadMax32[12:0];
		endcase
	end

	// disabling faults and sleep gate the drives
	wire driveEn = awake_q & ~rstIn & ~regUv & ~logicUv & ~bootFault_q;

	// one sequencer per phase, shared dead time
	genvar p;
	generate
		for (p = 0; p < 2; p = p + 1) begin : gPhase
			fbgd_phase uPhase (
				.clk(clk),
				.rst_n(rst_n),
				.enable(driveEn),
				.highCmd(hiCmd[p]),
				.lowCmd(loCmd[p]),
				.bootLow(bootOffLow_q[p]),
				.bootOk(~bootOnLow[p]),
				.deadCyc(deadCyc),
				.highGate(high_gate_out[p]),
				.lowGate(low_gate_out[p]),
				.chargeTimeout(chgHigh_q[p])
			);
		end
	endgenerate

	assign gatesActive = awake_q;

	always @(posedge clk) begin
		if (!rst_n)
			faultOe <= 1'b1;
		else
			faultOe <= ~asleep & (otSync | regUv | logicUv | bootFault_q);
	end
	assign faultOut = 1'b0;
endmodule
`default_nettype wire

// file: pkg/fbgd_defines.vh
`ifndef FBGD_DEFINES_VH
`define FBGD_DEFINES_VH

// clock rate in kHz (20 MHz)
`define FBGD_CLK_KHZ 20000
// charge pump hold-off after wake, microseconds
`define FBGD_WAKE_US 3000
`define FBGD_WAKE_CYC ((`FBGD_WAKE_US * `FBGD_CLK_KHZ) / 1000)
// maximum dead time, nanoseconds
`define FBGD_DEAD_MAX_NS 6000
`define FBGD_DEAD_MAX_CYC ((`FBGD_DEAD_MAX_NS * `FBGD_CLK_KHZ) / 1000000)
// minimum bootstrap charge time, nanoseconds (round up)
`define FBGD_CHG_MIN_NS 7000
`define FBGD_CHG_MIN_CYC ((`FBGD_CHG_MIN_NS * `FBGD_CLK_KHZ + 999999) / 1000000)
// bootstrap charge timeout, microseconds
`define FBGD_CHG_TMO_US 200
`define FBGD_CHG_TMO_CYC ((`FBGD_CHG_TMO_US * `FBGD_CLK_KHZ) / 1000)
// reset pulse time that clears the latched fault, nanoseconds
`define FBGD_RES_PULSE_NS 1000
`define FBGD_RES_PULSE_CYC ((`FBGD_RES_PULSE_NS * `FBGD_CLK_KHZ + 999999) / 1000000)
// sleep entry time after reset input falls, microseconds
`define FBGD_SLEEP_US 1000
`define FBGD_SLEEP_CYC ((`FBGD_SLEEP_US * `FBGD_CLK_KHZ) / 1000)

// dead time select codes
`define FBGD_DT_NONE 2'h0
`define FBGD_DT_RES 2'h1
`define FBGD_DT_MAX 2'h2

// phase sequencer states
`define FBGD_ST_OFF 3'h0
`define FBGD_ST_LOW 3'h1
`define FBGD_ST_HIGH 3'h2
`define FBGD_ST_DEAD 3'h3
`define FBGD_ST_CHG 3'h4

`endif

// file: test/fbgd_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module fbgd_host_model (
	// bench side
	input wire logic clk,
	input wire logic [4:0] req,
	// device side
	input wire logic faultOut,
	input wire logic faultOe,
	output logic [4:0] pins,
	output wire logic faultLine
);
	wire sepA = (req[1:0] == 2'h1 && pins[1]) || (req[1:0] == 2'h2 && pins[0]);
	wire sepB = (req[3:2] == 2'h1 && pins[3]) || (req[3:2] == 2'h2 && pins[2]);
	assign faultLine = faultOe ? faultOut : 1'b1;
	initial pins = 5'h10;
	always @(posedge clk)
		pins <= #1 {req[4], sepB ? 2'h0 : req[3:2], sepA ? 2'h0 : req[1:0]};
endmodule
`default_nettype wire

// file: test/fbgd_top_chk.sv
`timescale 1ns/1ps
`default_nettype none
module fbgd_top_chk (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// inputs
	input wire logic phase_a_high_cmd,
	input wire logic phase_a_low_cmd,
	input wire logic [1:0] dead_time_select,
	input wire logic overTemp,
	input wire logic regUnderVolt,
	input wire logic logicUnderVolt,
	// outputs
	input wire logic [1:0] high_gate_out,
	input wire logic [1:0] low_gate_out,
	input wire logic faultOut,
	input wire logic faultOe,
	input wire logic gatesActive,
	input wire logic asleep
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_no_shoot: assert property ((high_gate_out & low_gate_out) == 2'h0)
		else $error("both gates of a phase on");
	a_cross_low: assert property ((phase_a_high_cmd && phase_a_low_cmd)[*6] |-> !high_gate_out[0])
		else $error("high gate on with both commands");
	a_high_idle: assert property ((!phase_a_high_cmd)[*6] |-> !high_gate_out[0])
		else $error("high gate on without command");
	a_sleep_off: assert property (asleep |-> (high_gate_out | low_gate_out) == 2'h0)
		else $error("gate on while asleep");
	a_lv_off: assert property (logicUnderVolt[*6] |-> (high_gate_out | low_gate_out) == 2'h0)
		else $error("gate on in logic undervoltage");
	a_reg_off: assert property (regUnderVolt[*6] |-> (high_gate_out | low_gate_out) == 2'h0)
		else $error("gate on in regulator undervoltage");
	a_temp_flag: assert property (overTemp[*6] ##0 (!asleep)[*3] |-> faultOe)
		else $error("fault line released in overtemperature");
	a_open_drain: assert property (faultOut == 1'b0)
		else $error("fault line driven high");
	a_dead_gap: assert property ($fell(high_gate_out[0]) && dead_time_select == 2'h2 |-> (!low_gate_out[0])[*8])
		else $error("low gate on inside dead time");
	a_inactive_off: assert property (!gatesActive |-> ##1 (high_gate_out | low_gate_out) == 2'h0)
		else $error("gate on while drives inactive");
endmodule
bind fbgd_top fbgd_top_chk u_chk (.clk(clk), .rst_n(rst_n), .phase_a_high_cmd(phase_a_high_cmd),
	.phase_a_low_cmd(phase_a_low_cmd), .dead_time_select(dead_time_select), .overTemp(overTemp),
	.regUnderVolt(regUnderVolt), .logicUnderVolt(logicUnderVolt), .high_gate_out(high_gate_out),
	.low_gate_out(low_gate_out), .faultOut(faultOut), .faultOe(faultOe), .gatesActive(gatesActive),
	.asleep(asleep));
`default_nettype wire

// file: test/fbgd_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module fbgd_top_tb;
	logic clk, rst_n, overTemp, regUnderVolt, logicUnderVolt, pumpReady, probe;
	logic faultOut, faultOe, faultLine, gatesActive, asleep;
	logic [1:0] dts, bootBelowOn, bootBelowOff, hi, lo;
	logic [3:0] c, rnd;
	logic [4:0] req, pins;
	logic [4:0] expQ[$];
	int n_errors = 0;
	int checks_done = 0;
	fbgd_top #(.WAKE_CYC(20), .SLEEP_CYC(50), .RES_DEAD_CYC(13'h0014)) DUT (.clk(clk), .rst_n(rst_n),
		.phase_a_high_cmd(pins[0]), .phase_a_low_cmd(pins[1]), .phase_b_high_cmd(pins[2]),
		.phase_b_low_cmd(pins[3]), .reset_sleep_n(pins[4]), .dead_time_select(dts), .overTemp(overTemp),
		.regUnderVolt(regUnderVolt), .logicUnderVolt(logicUnderVolt), .pumpReady(pumpReady),
		.bootBelowOn(bootBelowOn), .bootBelowOff(bootBelowOff), .high_gate_out(hi), .low_gate_out(lo),
		.gatesActive(gatesActive), .faultOut(faultOut), .faultOe(faultOe), .asleep(asleep));
	fbgd_host_model host (.clk(clk), .req(req), .faultOut(faultOut), .faultOe(faultOe), .pins(pins),
		.faultLine(faultLine));
	function automatic logic [4:0] ex(input logic [3:0] k, input logic f);
		return {f, k[2] & ~k[3], k[0] & ~k[1], k[3], k[1]};
	endfunction
	task automatic check(input logic [4:0] seen, input logic [4:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic hold(input logic [4:0] r, input int n);
		req = r;
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic step(input logic [4:0] r, input int n, input logic [4:0] e);
		hold(r, n);
		expQ.push_back(e);
		probe = 1;
		@(posedge clk);
		#1 probe = 0;
	endtask
	task automatic report_and_stop;
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// result watcher
	always @(negedge clk) begin
		if (probe)
			check({faultLine, hi, lo}, expQ.pop_front());
	end
	initial begin
		clk = 0;
		forever #25 clk = ~clk;
	end
	initial begin
		repeat (40000) @(posedge clk);
		n_errors++;
		report_and_stop;
	end
	initial begin
		rst_n = 0;
		req = 5'h10;
		probe = 0;
		dts = 2'h0;
		overTemp = 0;
		regUnderVolt = 0;
		logicUnderVolt = 1;
		pumpReady = 1;
		bootBelowOn = 2'h0;
		bootBelowOff = 2'h0;
		rnd = $urandom(32'hf1f4aa92);
		rnd = $urandom;
		repeat (4) @(posedge clk);
		#1 rst_n = 1;
		step(5'h11, 40, 5'h00);
		logicUnderVolt = 0;
		step(5'h11, 10, ex(4'h1, 1));
		for (int i = 0; i < 16; i++) begin
			c = i[3:0] ^ rnd;
			step({1'b1, c}, 10, ex(c, 1));
		end
		$display("test power-up and truth table done");
		step(5'h10, 200, 5'h10);
		dts = 2'h2;
		step(5'h11, 10, ex(4'h1, 1));
		step(5'h12, 40, 5'h10);
		step(5'h12, 100, ex(4'h2, 1));
		step(5'h10, 200, 5'h10);
		step(5'h11, 10, ex(4'h1, 1));
		dts = 2'h1;
		step(5'h12, 8, 5'h10);
		step(5'h12, 30, ex(4'h2, 1));
		dts = 2'h0;
		step(5'h11, 8, ex(4'h1, 1));
		$display("test dead time done");
		overTemp = 1;
		step(5'h11, 10, ex(4'h1, 0));
		overTemp = 0;
		step(5'h11, 10, ex(4'h1, 1));
		regUnderVolt = 1;
		step(5'h11, 10, 5'h00);
		regUnderVolt = 0;
		step(5'h11, 10, ex(4'h1, 1));
		$display("test unlatched faults done");
		step(5'h10, 10, 5'h10);
		bootBelowOn = 2'h1;
		bootBelowOff = 2'h1;
		step(5'h11, 10, ex(4'h2, 1));
		bootBelowOn = 2'h0;
		bootBelowOff = 2'h0;
		step(5'h11, 60, ex(4'h2, 1));
		step(5'h11, 150, ex(4'h1, 1));
		bootBelowOn = 2'h1;
		bootBelowOff = 2'h1;
		step(5'h11, 10, ex(4'h2, 1));
		bootBelowOn = 2'h0;
		bootBelowOff = 2'h0;
		step(5'h11, 200, ex(4'h1, 1));
		$display("test charge cycles done");
		for (int m = 0; m < 3; m++) begin
			step(5'h10, 10, 5'h10);
			bootBelowOn = 2'h2;
			bootBelowOff = 2'h2;
			step(5'h14, 3900, ex(4'h8, 1));
			step(5'h14, 200, 5'h00);
			bootBelowOn = 2'h0;
			bootBelowOff = 2'h0;
			step(5'h14, 20, 5'h00);
			if (m == 0) begin
				logicUnderVolt = 1;
				step(5'h14, 10, 5'h00);
				logicUnderVolt = 0;
			end else if (m == 1) begin
				hold(5'h04, 25);
			end else begin
				step(5'h04, 80, 5'h10);
				pumpReady = 0;
				step(5'h14, 40, 5'h10);
				pumpReady = 1;
			end
			step(5'h14, 60, ex(4'h4, 1));
		end
		$display("test latched fault done");
		report_and_stop;
	end
endmodule
`default_nettype wire
